// [acc_top.sv]
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module acc_top #(
  parameter int NUM_CMP = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CMP-1:0] cmp_raw,
  input wire logic [NUM_CMP-1:0] pin_direction,
  input wire logic [NUM_CMP-1:0] port_latch,
  input wire logic gate_timer_clk,
  input wire logic gate_timer_clk_presc,
  input wire logic gate_timer_presc_used,
  output logic [NUM_CMP-1:0] analog_enable,
  output logic [NUM_CMP-1:0] analog_speed,
  output logic [NUM_CMP-1:0] analog_hyst,
  output logic [NUM_CMP-1:0] pin_out,
  output logic [NUM_CMP-1:0] pin_oe,
  output logic [NUM_CMP-1:0] gate_source,
  output logic [NUM_CMP-1:0] cmp_irq_flag,
  output logic [NUM_CMP-1:0] cmp_irq_req
);

  // elaboration check: one or two comparators only
  if (NUM_CMP < 1 || NUM_CMP > acc_pkg::ACC_MAX_CMP) begin : g_bad_count
    $error("acc_top: NUM_CMP must be 1 or 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  acc_pkg::acc_main_s main_q [NUM_CMP]; // per comparator main controls
  acc_pkg::acc_irq_s irq_q [NUM_CMP]; // per comparator irq controls
  logic [NUM_CMP-1:0] raw_meta_q; // first sync stage, read by stage two only
  logic [NUM_CMP-1:0] raw_sync_q; // synchronised raw comparison
  logic [NUM_CMP-1:0] eff_d; // on-gated, polarity adjusted result
  logic [NUM_CMP-1:0] res_q; // internal result, sampled every cycle
  logic [NUM_CMP-1:0] res_prev_q; // previous sample for edge detect
  logic [NUM_CMP-1:0] rise_ev; // one-cycle rising event
  logic [NUM_CMP-1:0] fall_ev; // one-cycle falling event
  logic [NUM_CMP-1:0] latched_q; // result held at timer falling edge
  logic [NUM_CMP-1:0] out_d; // result seen by status and gate
  logic [NUM_CMP-1:0] flag_q; // sticky interrupt flags
  logic [NUM_CMP-1:0] flag_clr; // software clear strobe per flag
  logic [2:0] tclk_q; // timer source clock: meta, sync, previous
  logic [2:0] tpre_q; // prescaled timer clock: meta, sync, previous
  logic tfall; // selected timer clock falling edge
  logic wr_en; // write takes effect this edge
  logic rd_en; // read data captured this edge
  logic addr_hit; // address maps to a register
  logic [31:0] rdata_d; // read mux output
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, so every access takes three cycles, setup included

  // ready rises in the second access cycle, then drops for the next transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel & penable & ~pready_q;
    end
  end

  // the edge that sees ready high completes the transfer
  assign wr_en = psel & penable & pready_q & pwrite;
  assign rd_en = psel & penable & ~pready_q & ~pwrite;

  // address decode, used for the error answer only; the read mux decodes the address itself
  always_comb
  begin
    addr_hit = 1'b0;
    if (paddr == acc_pkg::ACC_OFS_MIRROR || paddr == acc_pkg::ACC_OFS_FLAGS)
    begin
      addr_hit = 1'b1;
    end
    for (int i = 0; i < NUM_CMP; i++)
    begin
      if (paddr == acc_pkg::ACC_OFS_MAIN0 + 8'(i) * acc_pkg::ACC_OFS_STRIDE ||
          paddr == acc_pkg::ACC_OFS_IRQ0 + 8'(i) * acc_pkg::ACC_OFS_STRIDE)
      begin
        addr_hit = 1'b1;
      end
    end
  end

  // error flags an unmapped address, raised together with ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr_q <= 1'b0;
    end
    else
    begin
      pslverr_q <= psel & penable & ~pready_q & ~addr_hit;
    end
  end

  // read mux; reserved and unmapped bits read as zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (paddr == acc_pkg::ACC_OFS_MIRROR)
    begin
      rdata_d[NUM_CMP-1:0] = out_d; // shared_result_mirror bits
    end
    if (paddr == acc_pkg::ACC_OFS_FLAGS)
    begin
      rdata_d[NUM_CMP-1:0] = flag_q;
    end
    for (int i = 0; i < NUM_CMP; i++)
    begin
      if (paddr == acc_pkg::ACC_OFS_MAIN0 + 8'(i) * acc_pkg::ACC_OFS_STRIDE)
      begin
        rdata_d[acc_pkg::ACC_MAIN_ON] = main_q[i].comparator_on;
        rdata_d[acc_pkg::ACC_MAIN_RESULT] = out_d[i]; // cmp_result_bit
        rdata_d[acc_pkg::ACC_MAIN_DRIVE] = main_q[i].pin_drive_enable;
        rdata_d[acc_pkg::ACC_MAIN_INVERT] = main_q[i].invert_output;
        rdata_d[acc_pkg::ACC_MAIN_SPEED] = main_q[i].speed_power_select;
        rdata_d[acc_pkg::ACC_MAIN_HYS] = main_q[i].hysteresis_on;
        rdata_d[acc_pkg::ACC_MAIN_SYNC] = main_q[i].timer_sync_enable;
      end
      if (paddr == acc_pkg::ACC_OFS_IRQ0 + 8'(i) * acc_pkg::ACC_OFS_STRIDE)
      begin
        rdata_d[acc_pkg::ACC_IRQ_IE] = irq_q[i].cmp_irq_enable;
        rdata_d[acc_pkg::ACC_IRQ_RISE] = irq_q[i].rise_irq_enable;
        rdata_d[acc_pkg::ACC_IRQ_FALL] = irq_q[i].fall_irq_enable;
      end
    end
  end

  // read data captured one cycle before ready, held through it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      prdata_q <= rdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // gate timer clock synchronisers and falling edge select

  // two stages before use, third stage only for the edge compare
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tclk_q <= 3'h0;
      tpre_q <= 3'h0;
    end
    else
    begin
      tclk_q <= {tclk_q[1:0], gate_timer_clk};
      tpre_q <= {tpre_q[1:0], gate_timer_clk_presc};
    end
  end

  // prescaled clock takes over when the timer divides its source
  // latching on the falling edge keeps it away from the counting edge
  assign tfall = gate_timer_presc_used ? (tpre_q[2] & ~tpre_q[1]) : (tclk_q[2] & ~tclk_q[1]);

  // software clears a flag by writing one to its bit
  assign flag_clr = (wr_en && paddr == acc_pkg::ACC_OFS_FLAGS) ? pwdata[NUM_CMP-1:0] : '0;

  //////////////////////////////////////////////////////////////////////////////
  // per comparator logic

  for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp // instance count set here

    // controls; speed select leaves reset at normal speed
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        main_q[g] <= acc_pkg::ACC_MAIN_RESET;
      end
      else if (wr_en && paddr == acc_pkg::ACC_OFS_MAIN0 + 8'(g) * acc_pkg::ACC_OFS_STRIDE)
      begin
        main_q[g].comparator_on <= pwdata[acc_pkg::ACC_MAIN_ON];
        main_q[g].pin_drive_enable <= pwdata[acc_pkg::ACC_MAIN_DRIVE];
        main_q[g].invert_output <= pwdata[acc_pkg::ACC_MAIN_INVERT];
        main_q[g].speed_power_select <= pwdata[acc_pkg::ACC_MAIN_SPEED];
        main_q[g].hysteresis_on <= pwdata[acc_pkg::ACC_MAIN_HYS];
        main_q[g].timer_sync_enable <= pwdata[acc_pkg::ACC_MAIN_SYNC];
      end
    end

    // interrupt controls
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        irq_q[g] <= acc_pkg::ACC_IRQ_RESET;
      end
      else if (wr_en && paddr == acc_pkg::ACC_OFS_IRQ0 + 8'(g) * acc_pkg::ACC_OFS_STRIDE)
      begin
        irq_q[g].cmp_irq_enable <= pwdata[acc_pkg::ACC_IRQ_IE];
        irq_q[g].rise_irq_enable <= pwdata[acc_pkg::ACC_IRQ_RISE];
        irq_q[g].fall_irq_enable <= pwdata[acc_pkg::ACC_IRQ_FALL];
      end
    end

    // raw analog decision is asynchronous to pclk; high means noninverting above
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        raw_meta_q[g] <= 1'b0;
        raw_sync_q[g] <= 1'b0;
      end
      else
      begin
        raw_meta_q[g] <= cmp_raw[g];
        raw_sync_q[g] <= raw_meta_q[g];
      end
    end

    // a disabled comparator reads low, then polarity is applied
    // so toggling on or invert alone can change the result
    assign eff_d[g] = (main_q[g].comparator_on & raw_sync_q[g]) ^ main_q[g].invert_output;

    // internal result sampled every cycle, previous kept for edges
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        res_q[g] <= 1'b0;
        res_prev_q[g] <= 1'b0;
      end
      else
      begin
        res_q[g] <= eff_d[g];
        res_prev_q[g] <= res_q[g];
      end
    end

    // one-cycle edge events from consecutive samples
    assign rise_ev[g] = res_q[g] & ~res_prev_q[g];
    assign fall_ev[g] = ~res_q[g] & res_prev_q[g];

    // hold the result from one timer falling edge to the next
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        latched_q[g] <= 1'b0;
      end
      else if (tfall)
      begin
        latched_q[g] <= res_q[g];
      end
    end

    // sync on: status and gate see the timer-latched copy
    assign out_d[g] = main_q[g].timer_sync_enable ? latched_q[g] : res_q[g];

    // sticky flag; an enabled edge wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        flag_q[g] <= 1'b0;
      end
      else if ((rise_ev[g] & irq_q[g].rise_irq_enable) | (fall_ev[g] & irq_q[g].fall_irq_enable))
      begin
        flag_q[g] <= 1'b1;
      end
      else if (flag_clr[g])
      begin
        flag_q[g] <= 1'b0;
      end
    end

    // outputs, all from flops; the pin path costs one cycle of delay
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        analog_enable[g] <= 1'b0;
        analog_speed[g] <= 1'b1;
        analog_hyst[g] <= 1'b0;
        pin_out[g] <= 1'b0;
        pin_oe[g] <= 1'b0;
        gate_source[g] <= 1'b0;
        cmp_irq_flag[g] <= 1'b0;
        cmp_irq_req[g] <= 1'b0;
      end
      else
      begin
        analog_enable[g] <= main_q[g].comparator_on; // off means minimum current
        analog_speed[g] <= main_q[g].speed_power_select; // zero is low power
        analog_hyst[g] <= main_q[g].hysteresis_on; // amount follows speed in analog
        // drive enable replaces the port latch whatever the on bit
        pin_out[g] <= main_q[g].pin_drive_enable ? out_d[g] : port_latch[g];
        // driver on only with drive, output direction and comparator on
        pin_oe[g] <= main_q[g].pin_drive_enable & ~pin_direction[g] & main_q[g].comparator_on;
        gate_source[g] <= out_d[g]; // timer gate source, sync advised
        cmp_irq_flag[g] <= flag_q[g];
        cmp_irq_req[g] <= flag_q[g] & irq_q[g].cmp_irq_enable;
      end
    end

  end

endmodule

// [acc_pkg.sv]
package acc_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] ACC_OFS_MAIN0 = 8'h00;
  localparam logic [7:0] ACC_OFS_IRQ0 = 8'h04;
  localparam logic [7:0] ACC_OFS_STRIDE = 8'h08;
  localparam logic [7:0] ACC_OFS_MIRROR = 8'h10;
  localparam logic [7:0] ACC_OFS_FLAGS = 8'h14;

  // cmp_ctrl_main field positions
  localparam int ACC_MAIN_ON = 7;
  localparam int ACC_MAIN_RESULT = 6;
  localparam int ACC_MAIN_DRIVE = 5;
  localparam int ACC_MAIN_INVERT = 4;
  localparam int ACC_MAIN_SPEED = 2;
  localparam int ACC_MAIN_HYS = 1;
  localparam int ACC_MAIN_SYNC = 0;

  // cmp_ctrl_irq field positions
  localparam int ACC_IRQ_IE = 7;
  localparam int ACC_IRQ_RISE = 6;
  localparam int ACC_IRQ_FALL = 5;

  // control fields of cmp_ctrl_main
  typedef struct packed {
    logic comparator_on;
    logic pin_drive_enable;
    logic invert_output;
    logic speed_power_select;
    logic hysteresis_on;
    logic timer_sync_enable;
  } acc_main_s;

  // control fields of cmp_ctrl_irq
  typedef struct packed {
    logic cmp_irq_enable;
    logic rise_irq_enable;
    logic fall_irq_enable;
  } acc_irq_s;

  // reset values: all off except normal speed
  localparam acc_main_s ACC_MAIN_RESET = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  localparam acc_irq_s ACC_IRQ_RESET = '{1'b0, 1'b0, 1'b0};

  // largest comparator count the map can hold
  localparam int ACC_MAX_CMP = 2;

endpackage

// [acc_properties.sv]
`timescale 1ns/1ps
// watches bus answers, pin drive and sticky flags of acc_top
module acc_props #(
  parameter int NUM_CMP = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CMP-1:0] pin_direction,
  input wire logic [NUM_CMP-1:0] pin_oe,
  input wire logic [NUM_CMP-1:0] analog_enable,
  input wire logic [NUM_CMP-1:0] analog_speed,
  input wire logic [NUM_CMP-1:0] cmp_irq_flag
);
  // one clock domain, so one default clocking
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // completed transfer, the only moment a write lands
  logic done;
  assign done = psel && penable && pready;
  // write-1 clear mask of the flag register
  logic [NUM_CMP-1:0] clr;
  assign clr = (done && pwrite && paddr == acc_pkg::ACC_OFS_FLAGS) ? pwdata[NUM_CMP-1:0] : '0;
  ////////////////////////////////////////////////////////////
  chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_unmapped: assert property (done && paddr > acc_pkg::ACC_OFS_FLAGS |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_alone: assert property (pslverr |-> pready && paddr > acc_pkg::ACC_OFS_FLAGS)
    else $error("pslverr on a mapped access");
  chk_oe_needs_on: assert property ((pin_oe & ~analog_enable) == '0)
    else $error("pin driven by a disabled comparator");
  chk_oe_dir: assert property ((pin_oe & $past(pin_direction)) == '0)
    else $error("pin driven while direction is input");
  chk_speed_reset: assert property ($rose(presetn) |-> &analog_speed)
    else $error("speed select not normal after reset");
  chk_on_follows: assert property (done && pwrite && paddr == acc_pkg::ACC_OFS_MAIN0
    && pwdata[acc_pkg::ACC_MAIN_ON] |-> ##[1:2] analog_enable[0]) else $error("enable not passed on");
  chk_flag_sticky: assert property ((~cmp_irq_flag & $past(cmp_irq_flag) & ~$past(clr, 2)) == '0)
    else $error("flag dropped without a clear");
  // main scenarios reached
  cover property (|clr);
  cover property ($rose(cmp_irq_flag[0]));
  cover property ($rose(pin_oe[0]));
  cover property (done && pslverr);
endmodule

// [acc_far_model.sv]
`timescale 1ns/1ps
// far side: analog decision per comparator and gate timer clocks
module acc_far (
  input wire logic pclk,
  input wire logic [1:0] above,
  input wire logic wobble,
  output logic [1:0] cmp_raw,
  output logic gate_timer_clk,
  output logic gate_timer_clk_presc
);
  // free-running timer divider, the timer clock never stops
  logic [4:0] div_q = 5'h00;
  always @(posedge pclk)
    div_q <= div_q + 5'h01;
  // source clock 16 cycles, prescaled clock 32 cycles
  assign gate_timer_clk = div_q[3];
  assign gate_timer_clk_presc = div_q[4];
  // high when noninverting input is above; wobble models chatter each cycle
  assign cmp_raw = wobble ? {2{div_q[0]}} : above;
endmodule

// [tb.sv]
`timescale 1ns/1ps
// bench top: apb master, scenarios and verdict
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, es, wobble;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] cmp_raw, pin_direction, port_latch, analog_enable, analog_speed, analog_hyst;
  logic [1:0] pin_out, pin_oe, gate_source, cmp_irq_flag, cmp_irq_req, above;
  logic gate_timer_clk, gate_timer_clk_presc, gate_timer_presc_used;
  int err_count, checks_done;
  ////////////////////////////////////////////////////////////
  acc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cmp_raw, .pin_direction, .port_latch, .gate_timer_clk, .gate_timer_clk_presc, .gate_timer_presc_used,
    .analog_enable, .analog_speed, .analog_hyst, .pin_out, .pin_oe, .gate_source, .cmp_irq_flag, .cmp_irq_req);
  acc_far u_far (.pclk, .above, .wobble, .cmp_raw, .gate_timer_clk, .gate_timer_clk_presc);
  // 250 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  // one compare for every result, counted
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // apb transfer: held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    es = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, rd);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////
  // reset values, then speed and hysteresis bits reach the analog side
  task automatic t_reset();
    cmp("speed pins", 32'(analog_speed), 32'h3);
    rdc("main0", 8'h00, 32'h4);
    rdc("main1", 8'h08, 32'h4);
    rdc("irq0", 8'h04, 32'h0);
    rdc("flags", 8'h14, 32'h0);
    wr(8'h00, 32'h2);
    idle(2);
    cmp("speed hys", 32'({analog_speed, analog_hyst}), 32'h9);
  endtask
  // unmapped place is refused and reads zero
  task automatic t_unmapped();
    wr(8'h18, 32'hFF);
    cmp("err write", 32'(es), 32'h1);
    rdc("unmapped", 8'h18, 32'h0);
    cmp("err read", 32'(es), 32'h1);
  endtask
  // every input and polarity pair on both comparators
  task automatic t_polarity();
    logic [31:0] v;
    for (int i = 0; i < 2; i++)
      for (int k = 0; k < 4; k++)
      begin
        v = 32'h84 | (32'(k[1]) << 4);
        above[i] <= k[0];
        wr(8'(8 * i), v);
        idle(5);
        rdc("status", 8'(8 * i), v | (32'(k[0] ^ k[1]) << 6));
        rdc("mirror", 8'h10, 32'(k[0] ^ k[1]) << i);
        cmp("mirror bit", 32'(rd[i]), 32'(k[0] ^ k[1]));
        cmp("gate src", 32'(gate_source[i]), 32'(k[0] ^ k[1]));
      end
  endtask
  // pin takeover and output enable conditions
  task automatic t_pin();
    above <= 2'b11;
    port_latch <= 2'b01;
    pin_direction <= 2'b00;
    wr(8'h00, 32'h20);
    idle(3);
    cmp("pin off", 32'({pin_oe, pin_out}), 32'h0);
    cmp("enable off", 32'(analog_enable), 32'h2);
    wr(8'h00, 32'hA0);
    idle(5);
    cmp("pin on", 32'({pin_oe, pin_out}), 32'h5);
    cmp("enable on", 32'(analog_enable), 32'h3);
    pin_direction <= 2'b01;
    idle(3);
    cmp("pin input", 32'({pin_oe, pin_out}), 32'h1);
  endtask
  // edge enables, sticky flag, clear, and set winning over clear
  task automatic t_edges();
    wr(8'h00, 32'h00);
    wr(8'h04, 32'hC0); // enables set before expecting a flag
    wr(8'h00, 32'h10);
    idle(4);
    cmp("rise flag", 32'({cmp_irq_req[0], cmp_irq_flag[0]}), 32'h3);
    wr(8'h00, 32'h00);
    idle(4);
    cmp("sticky", 32'(cmp_irq_flag[0]), 32'h1);
    wr(8'h14, 32'h1);
    idle(4);
    cmp("cleared", 32'(cmp_irq_flag[0]), 32'h0);
    wr(8'h04, 32'h20);
    wr(8'h00, 32'h10);
    idle(4);
    cmp("rise masked", 32'(cmp_irq_flag[0]), 32'h0);
    wr(8'h00, 32'h00);
    idle(4);
    rdc("fall flag", 8'h14, 32'h1);
    wr(8'h04, 32'hE0);
    wr(8'h00, 32'h80);
    wobble <= 1'b1;
    idle(6);
    wr(8'h14, 32'h1);
    idle(2);
    cmp("set wins", 32'(cmp_irq_flag[0]), 32'h1);
    wobble <= 1'b0;
  endtask
  // result latched only on the selected timer clock's falling edge
  task automatic t_sync(input logic p);
    gate_timer_presc_used <= p;
    above[0] <= 1'b0;
    wr(8'h00, 32'h81); // timer sync for gating
    idle(40);
    if (p) @(negedge gate_timer_clk_presc); else @(negedge gate_timer_clk);
    idle(4);
    above[0] <= 1'b1;
    idle(p ? 20 : 8);
    cmp("sync hold", 32'(gate_source[0]), 32'h0);
    if (p) @(negedge gate_timer_clk_presc); else @(negedge gate_timer_clk);
    idle(6);
    cmp("sync take", 32'(gate_source[0]), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, wobble, gate_timer_presc_used} = 6'h0;
    {paddr, pwdata, above, pin_direction, port_latch} = '0;
    err_count = 0;
    checks_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_unmapped();
    t_polarity();
    t_pin();
    t_edges();
    t_sync(1'b0);
    t_sync(1'b1);
    stop_test();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #40000;
    err_count++;
    stop_test();
  end
endmodule
bind acc_top acc_props #(.NUM_CMP(NUM_CMP)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .pin_direction, .pin_oe, .analog_enable, .analog_speed, .cmp_irq_flag);
